/* src/pfb_host.sv */
// Host controller driving an asynchronous parallel flash over its pins.
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - Read: select and output enable low, write high.
// - Write: select and write low, output enable high.
// - Fast program mode only flags the write on prog_cycle_o.
// - One buffer load holds sixteen words maximum.
module pfb_host
  import pfb_pkg::*;
#(
  parameter int ADDR_W = 22
) (
  input  wire logic              clock_i,
  input  wire logic              rst_n_i,
  input  wire logic              clk_en_i,
  input  wire logic              req_valid_i,
  input  wire pfb_op_type        req_op_i,
  input  wire logic [ADDR_W-1:0] req_addr_i,
  input  wire logic [15:0]       req_data_i,
  input  wire logic              byte_mode_i,
  input  wire logic              fast_program_i,
  input  wire logic              write_protect_i,
  output logic                   req_ready_o,
  output logic                   rsp_valid_o,
  output logic [15:0]            rsp_data_o,
  output logic                   prog_cycle_o,
  output logic [ADDR_W-1:0]      flash_addr_o,
  output logic                   byte_lsb_o,
  output pfb_ctrl_type           flash_ctrl_o,
  output logic                   write_protect_n_o,
  output logic [15:0]            flash_dq_o,
  output logic [15:0]            flash_dq_oe_o,
  input  wire logic [15:0]       flash_dq_i
);
  // Two-stage synchroniser for the data pins; only stage two is read.
  logic [15:0]      dq_meta_r;        // First stage.
  logic [15:0]      dq_sync_r;        // Second stage.
  logic [15:0]      dq_sync_nxt;      // Next value of the second stage.
  // Controller state.
  pfb_state_type    state_r;          // Present state.
  pfb_state_type    state_nxt;        // Next state.
  logic [TIMER_W-1:0] timer_r;        // Cycles left in the phase.
  logic [TIMER_W-1:0] timer_nxt;      // Next timer value.
  logic [ADDR_W-1:0]  addr_r;         // Address on the pins.
  logic [ADDR_W-1:0]  addr_nxt;       // Next address.
  logic               lsb_r;          // Byte address bit.
  logic               lsb_nxt;        // Next byte address bit.
  logic [15:0]        wdata_r;        // Write data on the pins.
  logic [15:0]        wdata_nxt;      // Next write data.
  logic               width_r;        // Width select level, high = word.
  logic               width_nxt;      // Next width select.
  logic               page_ok_r;      // Open page held since select.
  logic               page_ok_nxt;    // Next page flag.
  logic               sel_r;          // Chip select held low.
  logic               sel_nxt;        // Next select.
  logic [15:0]        rdata_r;        // Captured read data.
  logic [15:0]        rdata_nxt;      // Next captured data.
  logic               rvalid_r;       // Read answer pulse.
  logic               rvalid_nxt;     // Next answer pulse.
  logic               fast_r;         // Write issued in fast program mode.
  logic               fast_nxt;       // Next fast flag.
  logic               same_page;      // Request stays in the open page.

  // The upper address bits name the page; only the low ones may move.
  // In byte mode the request address holds one more low bit, so the page
  // starts one bit higher there.
  assign same_page = page_ok_r && sel_r && (byte_mode_i == !width_r) &&
    (byte_mode_i ?
       (req_addr_i[ADDR_W-1:PAGE_LSB+1] == addr_r[ADDR_W-1:PAGE_LSB+1]) :
       (req_addr_i[ADDR_W-1:PAGE_LSB] == addr_r[ADDR_W-1:PAGE_LSB]));

  // Next-value logic of the whole bus sequencer.
  always_comb begin
    state_nxt   = state_r;
    timer_nxt   = timer_r;
    addr_nxt    = addr_r;
    lsb_nxt     = lsb_r;
    wdata_nxt   = wdata_r;
    width_nxt   = width_r;
    page_ok_nxt = page_ok_r;
    sel_nxt     = sel_r;
    rdata_nxt   = rdata_r;
    rvalid_nxt  = 1'b0;
    fast_nxt    = fast_r;
    dq_sync_nxt = dq_meta_r;
    case (state_r)
      PFB_IDLE: begin
        if (req_valid_i) begin
          addr_nxt  = req_addr_i;
          lsb_nxt   = req_addr_i[0];
          width_nxt = !byte_mode_i;
          wdata_nxt = req_data_i;
          case (req_op_i)
            PFB_OP_READ: begin
              sel_nxt   = 1'b1;
              state_nxt = PFB_RDWAIT;
              // Within an open page the shorter time suffices. The wait
              // also covers the two synchroniser stages, or the capture
              // would see pin data from before the access time ran out.
              if (same_page) begin
                timer_nxt = TIMER_W'(PAGE_ACCESS_CYC + SYNC_CYC);
              end else begin
                timer_nxt = TIMER_W'(RANDOM_ACCESS_CYC + SYNC_CYC);
              end
            end
            PFB_OP_WRITE: begin
              // A write ends the page; the next read starts afresh.
              sel_nxt     = 1'b0;
              page_ok_nxt = 1'b0;
              fast_nxt    = fast_program_i;
              timer_nxt   = TIMER_W'(WRITE_PULSE_CYC);
              state_nxt   = PFB_WRLOW;
            end
            PFB_OP_RESET: begin
              sel_nxt     = 1'b0;
              page_ok_nxt = 1'b0;
              timer_nxt   = TIMER_W'(RESET_PULSE_CYC);
              state_nxt   = PFB_RSTLOW;
            end
            default: begin
              state_nxt = PFB_IDLE;
            end
          endcase
        end
      end
      PFB_RDWAIT: begin
        if (timer_r <= TIMER_W'(1)) begin
          rdata_nxt   = width_r ? dq_sync_r : {8'h00, dq_sync_r[7:0]};
          rvalid_nxt  = 1'b1;
          page_ok_nxt = 1'b1;
          state_nxt   = PFB_IDLE;
        end else begin
          timer_nxt = timer_r - TIMER_W'(1);
        end
      end
      PFB_WRLOW: begin
        // Write strobe falls with chip select, or alone if a page read held select low, so the address is taken at once.
        if (timer_r <= TIMER_W'(1)) begin
          timer_nxt = TIMER_W'(WRITE_HIGH_CYC);
          state_nxt = PFB_WRHIGH;
        end else begin
          timer_nxt = timer_r - TIMER_W'(1);
        end
      end
      PFB_WRHIGH: begin
        // Recovery with strobes high so the device latches cleanly.
        if (timer_r <= TIMER_W'(1)) begin
          state_nxt = PFB_IDLE;
        end else begin
          timer_nxt = timer_r - TIMER_W'(1);
        end
      end
      PFB_RSTLOW: begin
        if (timer_r <= TIMER_W'(1)) begin
          state_nxt = PFB_IDLE;
        end else begin
          timer_nxt = timer_r - TIMER_W'(1);
        end
      end
      default: begin
        state_nxt = PFB_IDLE;
      end
    endcase
  end

  // Registers only; the clock enable freezes everything.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r   <= PFB_IDLE;
      timer_r   <= '0;
      addr_r    <= '0;
      lsb_r     <= 1'b0;
      wdata_r   <= 16'h0000;
      width_r   <= 1'b1;
      page_ok_r <= 1'b0;
      sel_r     <= 1'b0;
      rdata_r   <= 16'h0000;
      rvalid_r  <= 1'b0;
      fast_r    <= 1'b0;
      dq_meta_r <= 16'h0000;
      dq_sync_r <= 16'h0000;
    end else if (clk_en_i) begin
      state_r   <= state_nxt;
      timer_r   <= timer_nxt;
      addr_r    <= addr_nxt;
      lsb_r     <= lsb_nxt;
      wdata_r   <= wdata_nxt;
      width_r   <= width_nxt;
      page_ok_r <= page_ok_nxt;
      sel_r     <= sel_nxt;
      rdata_r   <= rdata_nxt;
      rvalid_r  <= rvalid_nxt;
      fast_r    <= fast_nxt;
      dq_meta_r <= flash_dq_i;
      dq_sync_r <= dq_sync_nxt;
    end
  end

  // Pin drive. Chip select stays low between page reads to keep the page.
  logic wr_phase;                     // Write strobe low phase.
  logic rd_phase;                     // Read phase.
  assign wr_phase = (state_r == PFB_WRLOW);
  assign rd_phase = (state_r == PFB_RDWAIT);
  assign flash_ctrl_o.chip_select_n    = !(rd_phase || wr_phase || sel_r);
  assign flash_ctrl_o.output_enable_n  = !rd_phase;
  assign flash_ctrl_o.write_enable_n   = !wr_phase;
  assign flash_ctrl_o.hardware_reset_n = (state_r != PFB_RSTLOW);
  assign flash_ctrl_o.width_select_n   = width_r;
  assign write_protect_n_o = !write_protect_i;
  assign flash_addr_o      = width_r ? addr_r : (addr_r >> 1);
  assign byte_lsb_o        = lsb_r;
  // Data driven only while writing; in byte mode line 15 carries address.
  assign flash_dq_o    = width_r ? wdata_r : {lsb_r, 7'h00, wdata_r[7:0]};
  assign flash_dq_oe_o = width_r ? {16{wr_phase || state_r == PFB_WRHIGH}}
                       : {!rd_phase || 1'b1, 7'h00,
                          {8{wr_phase || state_r == PFB_WRHIGH}}};
  assign req_ready_o  = (state_r == PFB_IDLE);
  assign rsp_valid_o  = rvalid_r;
  assign rsp_data_o   = rdata_r;
  assign prog_cycle_o = fast_r;

  // Assertions on the pin protocol.
  read_levels_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    rd_phase |-> !flash_ctrl_o.chip_select_n && flash_ctrl_o.write_enable_n)
    else $error("read without proper strobes");
  write_levels_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    wr_phase |-> flash_ctrl_o.output_enable_n && !flash_ctrl_o.chip_select_n)
    else $error("write with output enable low");
  no_contend_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !flash_ctrl_o.output_enable_n |-> flash_dq_oe_o[14:0] == 15'h0000)
    else $error("host drives data during read");
  reset_len_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    $fell(flash_ctrl_o.hardware_reset_n) && clk_en_i
      |-> !flash_ctrl_o.hardware_reset_n [*8])
    else $error("reset pulse too short");
endmodule
`default_nettype wire

/* src/pfb_pkg.sv */
// Package for the parallel flash bus host controller.
package pfb_pkg;
  // Bus timing figures in nanoseconds.
  localparam int CLK_PERIOD_NS      = 4;
  localparam int RANDOM_ACCESS_NS   = 90;
  localparam int PAGE_ACCESS_NS     = 25;
  localparam int WRITE_PULSE_NS     = 35;
  localparam int WRITE_HIGH_NS      = 20;
  localparam int RESET_PULSE_MIN_NS = 500;
  // Cycle counts; least times round up to whole cycles.
  localparam int RANDOM_ACCESS_CYC  =
    (RANDOM_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PAGE_ACCESS_CYC    =
    (PAGE_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_PULSE_CYC    =
    (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_HIGH_CYC     =
    (WRITE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_PULSE_CYC    =
    (RESET_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Page geometry: eight words per page, sixteen bytes.
  localparam int PAGE_LSB           = 3;
  localparam int BUFFER_MAX_WORDS   = 16;
  localparam int BUFFER_MAX_BYTES   = 32;
  localparam int TIMER_W            = 8;
  // Pin data passes two flip-flops before the sequencer may read it.
  localparam int SYNC_CYC           = 2;
  // Request opcodes of the user port.
  typedef enum logic [1:0] {
    PFB_OP_READ  = 2'h0,
    PFB_OP_WRITE = 2'h1,
    PFB_OP_RESET = 2'h2
  } pfb_op_type;
  // Controller states, Gray coded in listed order; idle to write low and to or from reset low change two bits.
  typedef enum logic [2:0] {
    PFB_IDLE   = 3'h0,
    PFB_RDWAIT = 3'h1,
    PFB_WRLOW  = 3'h3,
    PFB_WRHIGH = 3'h2,
    PFB_RSTLOW = 3'h6
  } pfb_state_type;
  // Control pins toward the flash, all active low.
  typedef struct packed {
    logic chip_select_n;
    logic output_enable_n;
    logic write_enable_n;
    logic hardware_reset_n;
    logic width_select_n;
  } pfb_ctrl_type;
endpackage

/* bench/pfb_flash_model.sv */
// Behavioural flash device model seen from its pins.
`timescale 1ns/10ps
`default_nettype none
module pfb_flash_model
  import pfb_pkg::*;
#(
  parameter int ADDR_W = 22
) (
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire pfb_ctrl_type      ctrl_i,
  input  wire logic              wp_n_i,
  input  wire logic [15:0]       dq_i,
  output logic      [15:0]       dq_o
);
  logic [15:0]       mem [int]; // Written words; the rest show a pattern.
  logic [ADDR_W-1:0] wr_addr;   // Address taken at the later fall.
  logic [ADDR_W-1:3] page;      // Page of the open access.
  logic              open_page;
  logic              wr_on;
  logic [15:0]       word;
  logic [15:0]       drv;
  realtime           valid_t;   // Read data is good from this time on.
  realtime           wr_t;      // Time of the later strobe fall.
  wire logic bsel = ctrl_i.width_select_n ? 1'b0 : dq_i[15];
  initial begin
    open_page = 1'b0;
    wr_on = 1'b0;
    valid_t = 0;
    dq_o = 16'h0;
  end
  // A new page or a fresh select costs the full access time.
  always @(addr_i, ctrl_i, bsel) begin
    if (ctrl_i.chip_select_n || !ctrl_i.hardware_reset_n) begin
      open_page = 1'b0;
    end else if (!open_page || page != addr_i[ADDR_W-1:3]) begin
      valid_t = $realtime + RANDOM_ACCESS_NS;
      page = addr_i[ADDR_W-1:3];
      open_page = 1'b1;
    end else if ($realtime + PAGE_ACCESS_NS > valid_t) begin
      valid_t = $realtime + PAGE_ACCESS_NS;
    end
  end
  // Lines not driven toggle, so stale data can never pass for good.
  always #1 begin
    word = mem.exists(int'(addr_i)) ? mem[int'(addr_i)]
                                    : {~addr_i[7:0], addr_i[7:0]};
    if (!ctrl_i.width_select_n) begin
      word = {8'h00, bsel ? word[15:8] : word[7:0]};
    end
    drv = (!ctrl_i.chip_select_n && !ctrl_i.output_enable_n &&
           ctrl_i.write_enable_n && ctrl_i.hardware_reset_n &&
           $realtime >= valid_t) ? 16'hffff : 16'h0000;
    if (!ctrl_i.width_select_n) drv = drv & 16'h00ff;
    dq_o = (drv & word) | (~drv & ~dq_o);
  end
  // Write latch: address at the later fall, data at the earlier rise.
  // The host moves address and strobes in one step, so the address that
  // settles within the step of the fall is the one taken.
  always @(ctrl_i, addr_i) begin
    if (!ctrl_i.hardware_reset_n) begin
      wr_on = 1'b0;
    end else if (!wr_on && !ctrl_i.write_enable_n
                 && !ctrl_i.chip_select_n) begin
      wr_addr = addr_i;
      wr_t = $realtime;
      wr_on = 1'b1;
    end else if (wr_on && (ctrl_i.write_enable_n
                 || ctrl_i.chip_select_n)) begin
      wr_on = 1'b0;
      if (wp_n_i || wr_addr[ADDR_W-1:15] != 0) begin
        mem[int'(wr_addr)] = dq_i;
      end
    end else if (wr_on && $realtime == wr_t) begin
      wr_addr = addr_i;
    end
  end
endmodule
`default_nettype wire

/* bench/tb_parallel_flash_bus_interface.sv */
// Self-checking bench for the parallel flash host controller.
`timescale 1ns/10ps
`default_nettype none
module tb_parallel_flash_bus_interface;
  import pfb_pkg::*;
  logic          clock_i, rst_n_i, req_valid_i, byte_mode_i, clk_en_i;
  logic          fast_program_i, write_protect_i, req_ready_o;
  logic          rsp_valid_o, prog_cycle_o, byte_lsb_o, write_protect_n_o;
  pfb_op_type    req_op_i;
  logic [21:0]   req_addr_i, flash_addr_o;
  logic [15:0]   req_data_i, rsp_data_o, flash_dq_o, flash_dq_oe_o;
  logic [15:0]   dev_dq, dq_wire, mid_oe;
  pfb_ctrl_type  flash_ctrl_o, mid_ctrl;
  int            mismatches, n_compared, cyc, lat, we_lo, rst_lo;
  // Answer delays: access time, two synchroniser stages, one return edge.
  localparam int RAND_LAT = RANDOM_ACCESS_CYC + SYNC_CYC + 1;
  localparam int PAGE_LAT = PAGE_ACCESS_CYC + SYNC_CYC + 1;
  // Each data line follows whichever side enables it.
  assign dq_wire = (flash_dq_oe_o & flash_dq_o) | (~flash_dq_oe_o & dev_dq);
  pfb_host #(.ADDR_W(22)) i_dut (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .clk_en_i(clk_en_i), .req_valid_i(req_valid_i), .req_op_i(req_op_i),
    .req_addr_i(req_addr_i), .req_data_i(req_data_i),
    .byte_mode_i(byte_mode_i), .fast_program_i(fast_program_i),
    .write_protect_i(write_protect_i), .req_ready_o(req_ready_o),
    .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o),
    .prog_cycle_o(prog_cycle_o), .flash_addr_o(flash_addr_o),
    .byte_lsb_o(byte_lsb_o), .flash_ctrl_o(flash_ctrl_o),
    .write_protect_n_o(write_protect_n_o), .flash_dq_o(flash_dq_o),
    .flash_dq_oe_o(flash_dq_oe_o), .flash_dq_i(dq_wire));
  pfb_flash_model #(.ADDR_W(22)) i_dev (.addr_i(flash_addr_o),
    .ctrl_i(flash_ctrl_o), .wp_n_i(write_protect_n_o), .dq_i(dq_wire),
    .dq_o(dev_dq));
  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end
  // The whole run needs under 2000 cycles; 5000 leaves ample margin.
  always @(posedge clock_i) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      mismatches++;
      end_sim();
    end
  end
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task end_sim;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // One request; counts cycles to the answer and samples the pins.
  task req(input pfb_op_type op, input logic [21:0] a, input logic [15:0] d);
    @(negedge clock_i);
    while (req_ready_o !== 1'b1) @(negedge clock_i);
    req_valid_i = 1'b1;
    req_op_i = op;
    req_addr_i = a;
    req_data_i = d;
    @(negedge clock_i);
    req_valid_i = 1'b0;
    lat = 1;
    we_lo = 0;
    rst_lo = 0;
    while (lat < 400 && ((op == PFB_OP_READ) ? rsp_valid_o !== 1'b1
                                            : req_ready_o !== 1'b1)) begin
      if (lat == 3) begin
        mid_ctrl = flash_ctrl_o;
        mid_oe = flash_dq_oe_o;
      end
      if (flash_ctrl_o.write_enable_n === 1'b0) we_lo++;
      if (flash_ctrl_o.hardware_reset_n === 1'b0) rst_lo++;
      @(negedge clock_i);
      lat++;
    end
  endtask
  task rd(input logic [21:0] a, input int e_lat, input logic [15:0] e);
    req(PFB_OP_READ, a, 16'h0);
    chk("read latency", e_lat, lat);
    chk("read data", e, rsp_data_o);
  endtask
  task t_word;
    rd(22'h40, RAND_LAT, 16'hbf40);
    chk("read pins", 3'b001, {mid_ctrl[4:3], mid_ctrl[2]});
    chk("word width", 1, mid_ctrl.width_select_n);
    rd(22'h43, PAGE_LAT, 16'hbc43);
    rd(22'h48, RAND_LAT, 16'hb748);
  endtask
  task t_write;
    fast_program_i = 1'b1;
    req(PFB_OP_WRITE, 22'h8123, 16'hbeef);
    chk("write pins", 3'b010, {mid_ctrl[4:3], mid_ctrl[2]});
    chk("write drive", 16'hffff, mid_oe);
    chk("write pulse", WRITE_PULSE_CYC, we_lo);
    chk("fast flag", 1, prog_cycle_o);
    fast_program_i = 1'b0;
    rd(22'h8123, RAND_LAT, 16'hbeef);
  endtask
  task t_protect;
    write_protect_i = 1'b1;
    req(PFB_OP_WRITE, 22'h10, 16'h1234);
    chk("protect pin", 0, write_protect_n_o);
    rd(22'h10, RAND_LAT, 16'hef10);
    write_protect_i = 1'b0;
    req(PFB_OP_WRITE, 22'h11, 16'h5678);
    rd(22'h11, RAND_LAT, 16'h5678);
  endtask
  task t_byte;
    byte_mode_i = 1'b1;
    rd(22'h81, RAND_LAT, 16'h00bf);
    chk("byte width", 0, mid_ctrl.width_select_n);
    chk("byte select drive", 1, mid_oe[15]);
    chk("word address", 22'h40, flash_addr_o);
    rd(22'h80, PAGE_LAT, 16'h0040);
    // Byte 0x8f lies in the same sixteen-byte page as byte 0x80.
    rd(22'h8f, PAGE_LAT, 16'h00b8);
    byte_mode_i = 1'b0;
  endtask
  task t_reset;
    req(PFB_OP_RESET, 22'h0, 16'h0);
    chk("reset pulse", RESET_PULSE_CYC, rst_lo);
    rd(22'h48, RAND_LAT, 16'hb748);
  endtask
  // Freezing the enable mid-read stretches the answer by the frozen edges;
  // the read stays in the open page, so the page time applies.
  task t_freeze;
    fork
      rd(22'h48, PAGE_LAT + 10, 16'hb748);
      begin
        repeat (5) @(negedge clock_i);
        clk_en_i = 1'b0;
        repeat (10) @(negedge clock_i);
        clk_en_i = 1'b1;
      end
    join
  endtask
  initial begin
    {rst_n_i, req_valid_i, byte_mode_i, fast_program_i} = 4'h0;
    write_protect_i = 1'b0;
    clk_en_i = 1'b1;
    req_op_i = PFB_OP_READ;
    req_addr_i = 22'h0;
    req_data_i = 16'h0;
    {mismatches, n_compared, cyc} = 96'h0;
    repeat (3) @(negedge clock_i);
    rst_n_i = 1'b1;
    t_word;
    t_write;
    t_protect;
    t_byte;
    t_reset;
    t_freeze;
    end_sim;
  end
endmodule
`default_nettype wire
